/* File: lmre_core.sv */
// lmre_core: executes literal loads, accumulator stores, option load,
// software reset, no-op and return from interrupt.
// assumes one instruction per instr_valid pulse; data memory and the
// return stack are outside, reached through the mem_* and stack ports.
//
// Added by the designer: register access over APB and the address map.
`timescale 1ns/1ns
module lmre_core #(
    parameter int PW = 16
) (
    input  wire logic              clk,
    input  wire logic              reset,
    input  wire logic              clk_en,
    input  wire logic [13:0]       instr,
    input  wire logic              instr_valid,
    output logic                   instr_ready,
    output logic                   mem_we,
    output logic [PW-1:0]          mem_addr,
    output logic [7:0]             mem_wdata,
    input  wire logic [PW-1:0]     top_of_stack,
    output logic                   stack_pop,
    output logic [PW-1:0]          pc,
    output logic                   device_reset,
    output logic [7:0]             status_flags,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr
);
    import lmre_pkg::*;

    typedef struct packed {
        lmre_state_t   state;
        logic [7:0]    acc;
        logic [4:0]    bank_select_reg;
        logic [6:0]    pc_high_latch;
        logic [7:0]    option_reg;
        logic [PW-1:0] ptr0;
        logic [PW-1:0] ptr1;
        logic [7:0]    interrupt_control_reg;
        logic [7:0]    reset_cause_reg;
        logic [7:0]    status;
        logic [PW-1:0] pc;
        logic          mem_we;
        logic [PW-1:0] mem_addr;
        logic [7:0]    mem_wdata;
        logic          pop;
        logic          dev_rst;
        logic [31:0]   prdata;
        logic          pslverr;
    } lmre_state_s_t;

    lmre_state_s_t r;
    lmre_state_s_t next_r;

    function automatic logic [PW-1:0] step(input logic [PW-1:0] p,
                                           input logic dec);
        // natural modulo wrap of the fixed width keeps the range
        step = dec ? p - PW'(1) : p + PW'(1);
    endfunction

    logic          acc_ph;
    logic [PW-1:0] sel_ptr;
    logic [PW-1:0] upd_ptr;
    lmre_mode_t    mode;
    logic          ind_sel;

    assign acc_ph      = psel && penable;
    assign instr_ready = (r.state == ST_FETCH) && clk_en;
    // one wait state while an instruction is taken, so a bus write
    // never races that instruction's own register update
    assign pready      = !(instr_valid && instr_ready);
    assign mem_we      = r.mem_we;
    assign mem_addr    = r.mem_addr;
    assign mem_wdata   = r.mem_wdata;
    assign stack_pop   = r.pop;
    assign pc          = r.pc;
    assign device_reset = r.dev_rst;
    assign status_flags = r.status;
    assign prdata      = r.prdata;
    assign pslverr     = r.pslverr;

    always_comb begin
        next_r  = r;
        ind_sel = instr[2];
        mode    = lmre_mode_t'(instr[1:0]);
        sel_ptr = ind_sel ? r.ptr1 : r.ptr0;
        upd_ptr = step(sel_ptr, mode[0]);
        next_r.mem_we  = 1'b0;
        next_r.pop     = 1'b0;
        next_r.dev_rst = 1'b0;
        case (r.state)
            ST_FETCH: begin
                if (instr_valid) begin
                    next_r.pc = r.pc + PW'(1);
                    if (instr == OP_NOP) begin
                        next_r.pc = r.pc + PW'(1);
                    end else if (instr == OP_RETFI) begin
                        next_r.pop = 1'b1;
                        next_r.pc  = top_of_stack;
                        next_r.interrupt_control_reg[IRQ_EN_BIT] = 1'b1;
                        next_r.state = ST_RET2;
                    end else if (instr == OP_OPTLD) begin
                        next_r.option_reg = r.acc;
                    end else if (instr == OP_SWRST) begin
                        next_r.reset_cause_reg[RST_INSTR_BIT] = 1'b0;
                        next_r.dev_rst = 1'b1;
                        next_r.state   = ST_RST;
                    end else if (instr[13:5] == OP_BANK) begin
                        next_r.bank_select_reg = instr[4:0];
                    end else if (instr[13:7] == OP_PCL) begin
                        next_r.pc_high_latch = instr[6:0];
                    end else if (instr[13:8] == OP_ACCL) begin
                        next_r.acc = instr[7:0];
                    end else if (instr[13:7] == OP_STDIR) begin
                        // flags untouched; one-cycle write strobe
                        next_r.mem_we    = 1'b1;
                        next_r.mem_addr  = PW'({r.bank_select_reg,
                                                instr[6:0]});
                        next_r.mem_wdata = r.acc;
                    end else if (instr[13:3] == OP_STIND) begin
                        // the window is only a redirection; acc is stored at the pointer address
                        next_r.mem_we    = 1'b1;
                        next_r.mem_wdata = r.acc;
                        next_r.mem_addr  = mode[1] ? sel_ptr : upd_ptr;
                        if (ind_sel) next_r.ptr1 = upd_ptr;
                        else next_r.ptr0 = upd_ptr;
                    end else if (instr[13:7] == OP_STOFS) begin
                        // pointer left as it was
                        next_r.mem_we    = 1'b1;
                        next_r.mem_wdata = r.acc;
                        next_r.mem_addr  = (instr[6] ? r.ptr1 : r.ptr0)
                            + PW'($signed(instr[5:0]));
                    end
                end
            end
            ST_RET2: next_r.state = ST_FETCH;
            default: next_r.state = ST_FETCH;
        endcase
        // register bus; while clk_en is high, read data and error are registered through the
        // setup and wait cycles so they already stand at the access edge
        next_r.pslverr = 1'b0;
        if (psel && !pwrite) begin
            next_r.prdata = '0;
            if (paddr == A_ACC) next_r.prdata = 32'(r.acc);
            else if (paddr == A_BANK) next_r.prdata = 32'(r.bank_select_reg);
            else if (paddr == A_PCLAT) next_r.prdata = 32'(r.pc_high_latch);
            else if (paddr == A_OPTION) next_r.prdata = 32'(r.option_reg);
            else if (paddr == A_PTR0) next_r.prdata = 32'(r.ptr0);
            else if (paddr == A_PTR1) next_r.prdata = 32'(r.ptr1);
            else if (paddr == A_INTERRUPT_CONTROL_REG) next_r.prdata =
                32'(r.interrupt_control_reg);
            else if (paddr == A_RCAUSE) next_r.prdata = 32'(r.reset_cause_reg);
            else if (paddr == A_PC) next_r.prdata = 32'(r.pc);
            else if (paddr == A_CTRL) next_r.prdata = 32'(r.state);
            else next_r.pslverr = 1'b1;
        end else if (psel && pwrite) begin
            if (!(paddr == A_INTERRUPT_CONTROL_REG || paddr == A_RCAUSE ||
                  paddr == A_PTR0 || paddr == A_PTR1 ||
                  paddr == A_ACC || paddr == A_CTRL))
                next_r.pslverr = 1'b1;
        end
        if (acc_ph && pwrite && pready) begin
            if (paddr == A_INTERRUPT_CONTROL_REG)
                next_r.interrupt_control_reg = pwdata[7:0];
            else if (paddr == A_RCAUSE)
                next_r.reset_cause_reg = pwdata[7:0];
            else if (paddr == A_PTR0) next_r.ptr0 = pwdata[PW-1:0];
            else if (paddr == A_PTR1) next_r.ptr1 = pwdata[PW-1:0];
            else if (paddr == A_ACC) next_r.acc = pwdata[7:0];
        end
        if (!clk_en) next_r = r;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            r <= '0;
            r.state <= ST_FETCH;
            r.option_reg <= OPTION_RST;
            r.reset_cause_reg <= RCAUSE_RST;
        end else begin
            r <= next_r;
        end
    end
endmodule // lmre_core

/* File: lmre_core_checker.sv */
// lmre_core_checker: instruction timing and effects at the core's ports
// assumes it is bound onto lmre_core and sees only its ports
`timescale 1ns/1ns
module lmre_core_checker
    import lmre_pkg::*;
#(parameter int PW = 16) (
    input wire logic clk,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic [13:0] instr,
    input wire logic instr_valid,
    input wire logic instr_ready,
    input wire logic mem_we,
    input wire logic [PW-1:0] mem_addr,
    input wire logic stack_pop,
    input wire logic device_reset,
    input wire logic [7:0] status_flags,
    input wire logic pready
);
    wire logic tk = instr_valid && instr_ready;
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    flags_kept_a: assert property (status_flags == 8'h00)
        else $error("status flags moved");
    direct_store_a: assert property (tk && instr[13:7] == OP_STDIR |=>
        mem_we && mem_addr[6:0] == $past(instr[6:0])) else $error("direct");
    ind_store_a: assert property (tk && instr[13:3] == OP_STIND |=>
        mem_we) else $error("indirect store missing");
    ofs_store_a: assert property (tk && instr[13:7] == OP_STOFS |=>
        mem_we) else $error("offset store missing");
    ret_two_a: assert property (tk && instr == OP_RETFI |=>
        !instr_ready ##1 (instr_ready || !clk_en)) else $error("ret cycles");
    ret_pop_a: assert property (tk && instr == OP_RETFI |->
        ##[1:2] stack_pop) else $error("no stack pop");
    sw_reset_a: assert property (tk && instr == OP_SWRST |=>
        device_reset) else $error("no device reset");
    nop_quiet_a: assert property (tk && instr == OP_NOP |=>
        !mem_we && !stack_pop && !device_reset) else $error("nop acted");
    stall_gate_a: assert property (!clk_en |-> !instr_ready)
        else $error("ready while frozen");
    cover property (tk && instr == OP_RETFI);
    cover property (tk && instr[13:3] == OP_STIND);
    cover property (device_reset);
endmodule // lmre_core_checker
bind lmre_core lmre_core_checker #(.PW(PW)) u_lmre_core_checker (
    .clk(clk), .reset(reset), .clk_en(clk_en), .instr(instr),
    .instr_valid(instr_valid), .instr_ready(instr_ready), .mem_we(mem_we),
    .mem_addr(mem_addr), .stack_pop(stack_pop), .device_reset(device_reset),
    .status_flags(status_flags), .pready(pready));

/* File: lmre_core_tb.sv */
// lmre_core_tb: instruction and APB sequences with expected values
// assumes APB with waits; read data and error stand at the access edge
`timescale 1ns/1ns
module lmre_core_tb;
    import lmre_pkg::*;
    logic clk = 0, reset = 1, clk_en = 1, instr_valid = 0;
    logic psel = 0, penable = 0, pwrite = 0, pready, pslverr;
    logic mem_we, stack_pop, device_reset, instr_ready;
    logic [13:0] instr = 14'h0000;
    logic [15:0] mem_addr, pc, top_of_stack = 16'h1234;
    logic [7:0] paddr = 8'h00, mem_wdata, status_flags;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic err;
    int miscompares = 0, compares = 0;
    lmre_core u_lmre_core (.clk(clk), .reset(reset), .clk_en(clk_en),
        .instr(instr), .instr_valid(instr_valid), .instr_ready(instr_ready),
        .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .top_of_stack(top_of_stack), .stack_pop(stack_pop), .pc(pc),
        .device_reset(device_reset), .status_flags(status_flags),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));
    initial forever #2 clk = ~clk;
    task chk(input string n, input logic [31:0] s, input logic [31:0] e);
        compares++;
        if (s !== e) begin
            miscompares++;
            $display("BAD %s exp %h seen %h", n, e, s);
        end
    endtask
    task tally_and_finish;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        // taken at the very edge where pready is seen high
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // returns at the edge after the take, where the effects stand
    task exec(input logic [13:0] i);
        @(posedge clk);
        instr <= i;
        instr_valid <= 1'b1;
        do @(posedge clk); while (instr_ready !== 1'b1);
        instr_valid <= 1'b0;
        @(posedge clk);
    endtask
    initial begin
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        apb(0, A_OPTION, 0);
        chk("option_rst", rd, 32'h0000_00FF);
        apb(0, A_RCAUSE, 0);
        chk("rcause_rst", rd, 32'h0000_0004);
        apb(0, 8'hFC, 0);
        chk("unmapped", err, 1);
        exec({OP_ACCL, 8'hA5});
        apb(0, A_ACC, 0);
        chk("acc", rd, 32'h0000_00A5);
        exec({OP_BANK, 5'h1F});
        apb(0, A_BANK, 0);
        chk("bank", rd, 32'h0000_001F);
        exec({OP_PCL, 7'h7F});
        apb(0, A_PCLAT, 0);
        chk("pclat", rd, 32'h0000_007F);
        exec({OP_STDIR, 7'h55});
        chk("direct", {mem_we, mem_wdata, mem_addr}, {9'h1A5, 16'h0FD5});
        exec(OP_OPTLD);
        apb(0, A_OPTION, 0);
        chk("option", rd, 32'h0000_00A5);
        // start at the top so every mode crosses a wrap boundary
        apb(1, A_PTR0, 32'h0000_FFFF);
        for (int m = 0; m < 4; m++) begin
            exec({OP_STIND, 1'b0, m[1:0]});
            chk("ind_addr", mem_addr, (m == 1 || m == 2) ? 16'hFFFF : 0);
            apb(0, A_PTR0, 0);
            chk("ptr0", rd, m[0] ? 32'h0000_FFFF : 0);
        end
        apb(1, A_PTR1, 32'h0000_0010);
        exec({OP_STOFS, 1'b1, 6'h20});
        chk("ofs_lo", mem_addr, 16'hFFF0);
        exec({OP_STOFS, 1'b1, 6'h1F});
        chk("ofs_hi", mem_addr, 16'h002F);
        apb(0, A_PTR1, 0);
        chk("ptr1", rd, 32'h0000_0010);
        exec(OP_NOP);
        chk("nop", {mem_we, stack_pop, device_reset}, 0);
        apb(1, A_INTERRUPT_CONTROL_REG, 0);
        exec(OP_RETFI);
        chk("ret_busy", instr_ready, 0);
        chk("ret_pop", stack_pop, 1);
        chk("pc", pc, 16'h1234);
        apb(0, A_INTERRUPT_CONTROL_REG, 0);
        chk("gie", rd[IRQ_EN_BIT], 1);
        @(posedge clk) clk_en <= 1'b0;
        @(posedge clk);
        chk("frozen", instr_ready, 0);
        @(posedge clk) clk_en <= 1'b1;
        exec(OP_SWRST);
        chk("swrst", device_reset, 1);
        repeat (3) @(posedge clk);
        apb(0, A_RCAUSE, 0);
        chk("ri", rd[RST_INSTR_BIT], 0);
        chk("flags", status_flags, 0);
        tally_and_finish;
    end
    initial begin
        repeat (3000) @(posedge clk);
        miscompares++;
        tally_and_finish;
    end
endmodule // lmre_core_tb

/* File: lmre_pkg.sv */
// lmre_pkg: constants for the literal/move/return execution block
// assumes 14-bit instruction words and an APB register port
package lmre_pkg;
    localparam int IW = 14;
    // opcode patterns (bits above the operand field)
    localparam logic [13:0] OP_NOP     = 14'h0000;
    localparam logic [13:0] OP_RETFI   = 14'h0009;
    localparam logic [13:0] OP_OPTLD   = 14'h0062;
    localparam logic [13:0] OP_SWRST   = 14'h0001;
    localparam logic [8:0]  OP_BANK    = 9'h001;   // 000000 0 01 kkkkk
    localparam logic [6:0]  OP_PCL     = 7'h63;    // 11 0001 1 kkkkkkk
    localparam logic [5:0]  OP_ACCL    = 6'h30;    // 11 0000 kkkkkkkk
    localparam logic [6:0]  OP_STDIR   = 7'h01;    // 00 0000 1 fffffff
    localparam logic [10:0] OP_STIND   = 11'h003;  // 00 0000 0001 1 n mm
    localparam logic [6:0]  OP_STOFS   = 7'h7F;    // 11 1111 1 n kkkkkk
    // APB byte addresses
    localparam logic [7:0] A_CTRL   = 8'h00;
    localparam logic [7:0] A_ACC    = 8'h04;
    localparam logic [7:0] A_BANK   = 8'h08;
    localparam logic [7:0] A_PCLAT  = 8'h0C;
    localparam logic [7:0] A_OPTION = 8'h10;
    localparam logic [7:0] A_PTR0   = 8'h14;
    localparam logic [7:0] A_PTR1   = 8'h18;
    localparam logic [7:0] A_INTERRUPT_CONTROL_REG = 8'h1C;
    localparam logic [7:0] A_RCAUSE = 8'h20;
    localparam logic [7:0] A_PC     = 8'h24;
    localparam int IRQ_EN_BIT    = 7;
    localparam int RST_INSTR_BIT = 2;
    localparam logic [7:0] OPTION_RST = 8'hFF;
    localparam logic [7:0] RCAUSE_RST = 8'h04;
    typedef enum logic [1:0] {
        UPD_PREINC  = 2'b00,
        UPD_PREDEC  = 2'b01,
        UPD_POSTINC = 2'b10,
        UPD_POSTDEC = 2'b11
    } lmre_mode_t;
    typedef enum logic [1:0] {
        ST_FETCH = 2'b00,
        ST_RET2  = 2'b01,
        ST_RST   = 2'b10
    } lmre_state_t;
endpackage
